//--- common/nvsr_defs.svh
`ifndef NVSR_DEFS_SVH
`define NVSR_DEFS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define NVSR_CMD_WRITE_REGS   8'h01
`define NVSR_CMD_READ_ANY     8'h65
`define NVSR_CMD_WRITE_ANY    8'h71
`define NVSR_CMD_LATCH_SET    8'h06
`define NVSR_CMD_LATCH_CLR    8'h04
`define NVSR_CMD_READ_STATUS  8'h05
`define NVSR_CMD_CLEAR_STATUS 8'h30
`define NVSR_CMD_SOFT_RESET   8'hf0
`define NVSR_CMD_PROGRAM      8'h02
`define NVSR_CMD_SECTOR_ERASE 8'hd8
`define NVSR_CMD_BULK_ERASE   8'h60
// ----------------------------------------
// register addresses for any-register access
// ----------------------------------------
`define NVSR_ADDR_STATUS_ONE_NONVOLATILE 24'h000000
`define NVSR_ADDR_CONFIG_ONE_NONVOLATILE 24'h000002
`define NVSR_ADDR_STATUS_ONE_VOLATILE  24'h800000
`define NVSR_ADDR_CONFIG_ONE_VOLATILE  24'h800002
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define NVSR_BIT_LOCK      7
`define NVSR_BIT_PERR      6
`define NVSR_BIT_EERR      5
`define NVSR_BIT_WEL       1
`define NVSR_BIT_BUSY      0
`define NVSR_BP_HI         4
`define NVSR_BP_LO         2
`define NVSR_BIT_BP_VOLSEL 3
`define NVSR_BP_ALL_ONES   3'h7
`define NVSR_STATUS_ONE_NONVOLATILE_RESET   8'h00
`define NVSR_CONFIG_ONE_NONVOLATILE_RESET   8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define NVSR_CLK_NS        4
`define NVSR_NV_UPDATE_NS  4000
`define NVSR_NV_CYCLES     ((`NVSR_NV_UPDATE_NS + `NVSR_CLK_NS - 1) / `NVSR_CLK_NS)
`endif

//--- common/nvsr_pkg.sv
// ----------------------------------------
// types shared by the status register block
// ----------------------------------------
package nvsr_pkg;
    typedef enum logic [1:0] {
        NVSR_IDLE,
        NVSR_NV_WAIT,
        NVSR_ARRAY_WAIT
    } nvsr_phase_e;

    typedef logic [7:0] nvsr_byte_t;

    typedef struct packed {
        logic        sclkPrev;
        logic        csPrevN;
        logic [2:0]  bitCnt;
        logic [2:0]  byteCnt;
        nvsr_byte_t  rxSh;
        nvsr_byte_t  cmd;
        logic [15:0] hist;
        logic [23:0] addr;
        nvsr_byte_t  txSh;
        logic        rdActive;
        nvsr_byte_t  status_one_nonvolatile;
        nvsr_byte_t  config_one_nonvolatile;
        nvsr_byte_t  config_one_volatile;
        logic [2:0]  bpVol;
        logic        progErr;
        logic        eraseErr;
        logic        write_enable_latch;
        logic        busySeed;
        nvsr_phase_e phase;
        logic [15:0] waitCnt;
        nvsr_byte_t  pendSr;
        nvsr_byte_t  pendCr;
        logic        miso;
        logic        misoOe;
        logic        progPulse;
        logic        erasePulse;
        logic        bulkPulse;
        logic [23:0] arrayAddr;
    } nvsr_state_s;
endpackage : nvsr_pkg

//--- verilog/nvsr_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// two-stage synchroniser, one per bit
// ----------------------------------------
module nvsr_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);
    import nvsr_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } nvsr_sync_s;

    nvsr_sync_s state_reg;
    nvsr_sync_s state_next;

    // stage1 feeds only stage2
    always_comb begin
        state_next.stage1 = async;
        state_next.stage2 = state_reg.stage1;
    end

    // select and lock pin idle high (inactive), so every stage resets to ones
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign synced = state_reg.stage2;
endmodule : nvsr_sync

//--- verilog/nvsr_top.sv
`timescale 1ns/1ps
`include "nvsr_defs.svh"
// Function
// - lock bit set and lock pin low: ignore status/config one register writes
// - lock pin high: status/config one writes accepted whatever the lock bit
// - lock bit clear: lock pin has no effect on writes
// - lock pin never blocks writes to any other register
// - volatile lock copy always mirrors the non-volatile lock bit
// - program-error default seeds volatile flag, read-only, shipped as 0
// - erase-error default seeds volatile flag, read-only, shipped as 0
// - write-latch default seeds volatile latch, not host writable
// - busy default seeds volatile busy flag, not host writable
// - select bit 0: non-volatile protect bits rule; write copies into volatile ones
// - select bit 1: volatile protect bits rule; write leaves non-volatile ones
// - volatile protection: non-volatile protect bits forced to ones, then frozen
// - nonzero protect code refuses program/erase inside protected region
// - bulk erase runs only when all active protect bits are zero
// - every reset loads volatile registers from non-volatile ones
// - non-volatile write reprograms, then refreshes volatile copy
// - register writes, programs and erases need the write latch set
module nvsr_top #(
    parameter int NV_CYCLES = `NVSR_NV_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        mosi,
    input  wire logic        wpN,
    output logic             miso,
    output logic             misoOe,
    output logic             busy,
    output logic             arrayProgPulse,
    output logic             arrayErasePulse,
    output logic             arrayBulkPulse,
    output logic [23:0]      arrayAddr
);
    import nvsr_pkg::*;
    nvsr_state_s      state_reg;
    nvsr_state_s      state_next;
    logic [3:0]       pinSync;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    nvsr_sync #(
        .WIDTH (4)
    ) u_sync (
        .mclk   (mclk),
        .rst    (rst),
        .async  ({sclk, csN, mosi, wpN}),
        .synced (pinSync)
    );
    logic sclkS, csS_N, mosiS, wpS_N;
    assign {sclkS, csS_N, mosiS, wpS_N} = pinSync;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // top 1/8 .. 6/8 of the array; code 7 covers all of it
    function automatic logic inProtected(input logic [23:0] a, input logic [2:0] bp);
        inProtected = (bp == `NVSR_BP_ALL_ONES) |
                      ((bp != 3'h0) & ({1'b0, a[23:21]} >= (4'h8 - {1'b0, bp})));
    endfunction : inProtected
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nvsr_byte_t  status_one_volatile, rxByte, newSr, newCr;
        logic [23:0] regAddr;
        logic [2:0]  activeBp;
        logic        wpLock, isIdle, sclkRise, sclkFall, csRise, targetsOne;
        state_next = state_reg;
        state_next.progPulse  = 1'b0;
        state_next.erasePulse = 1'b0;
        state_next.bulkPulse  = 1'b0;
        sclkRise = sclkS & ~state_reg.sclkPrev & ~csS_N;
        sclkFall = ~sclkS & state_reg.sclkPrev & ~csS_N;
        csRise   = csS_N & ~state_reg.csPrevN;
        isIdle   = (state_reg.phase == NVSR_IDLE);
        state_next.sclkPrev = sclkS;
        state_next.csPrevN  = csS_N;
        // pin only matters while the lock bit is 1
        wpLock = state_reg.status_one_nonvolatile[`NVSR_BIT_LOCK] & ~wpS_N;
        activeBp = state_reg.config_one_nonvolatile[`NVSR_BIT_BP_VOLSEL] ? state_reg.bpVol
                 : state_reg.status_one_nonvolatile[`NVSR_BP_HI:`NVSR_BP_LO];
        status_one_volatile = {state_reg.status_one_nonvolatile[`NVSR_BIT_LOCK],
                state_reg.progErr, state_reg.eraseErr, state_reg.bpVol, state_reg.write_enable_latch,
                state_reg.busySeed | ~isIdle};
        rxByte  = {state_reg.rxSh[6:0], mosiS};
        regAddr = {state_reg.hist, rxByte};
        newSr = state_reg.status_one_nonvolatile;
        newCr = state_reg.config_one_nonvolatile;
        targetsOne = 1'b0;
        // serial receive on sclk rise, reads are shifted out on the fall
        if (sclkRise) begin
            state_next.rxSh   = rxByte;
            state_next.bitCnt = state_reg.bitCnt + 3'h1;
            if (state_reg.bitCnt == 3'h7) begin
                state_next.hist = {state_reg.hist[7:0], rxByte};
                if (state_reg.byteCnt != 3'h7) begin
                    state_next.byteCnt = state_reg.byteCnt + 3'h1;
                end
                if (state_reg.byteCnt == 3'h0) begin
                    state_next.cmd = rxByte;
                end
                if (state_reg.byteCnt == 3'h3) begin
                    state_next.addr = regAddr;
                end
                // status poll stays legal while busy, so it never waits on the phase
                if ((state_reg.byteCnt == 3'h0) ? (rxByte == `NVSR_CMD_READ_STATUS)
                                                : (state_reg.cmd == `NVSR_CMD_READ_STATUS)) begin
                    state_next.txSh     = status_one_volatile;
                    state_next.rdActive = 1'b1;
                end else if (state_reg.cmd == `NVSR_CMD_READ_ANY && state_reg.byteCnt >= 3'h3) begin
                    case ((state_reg.byteCnt == 3'h3) ? regAddr : state_reg.addr)
                        `NVSR_ADDR_STATUS_ONE_NONVOLATILE: state_next.txSh = state_reg.status_one_nonvolatile;
                        `NVSR_ADDR_CONFIG_ONE_NONVOLATILE: state_next.txSh = state_reg.config_one_nonvolatile;
                        `NVSR_ADDR_STATUS_ONE_VOLATILE:  state_next.txSh = status_one_volatile;
                        `NVSR_ADDR_CONFIG_ONE_VOLATILE:  state_next.txSh = state_reg.config_one_volatile;
                        default:          state_next.txSh = 8'h00;
                    endcase
                    state_next.rdActive = 1'b1;
                end
            end
        end
        if (sclkFall && state_reg.rdActive) begin
            state_next.miso   = state_reg.txSh[7];
            state_next.misoOe = 1'b1;
            state_next.txSh   = {state_reg.txSh[6:0], 1'b0};
        end
        // commands take effect when select rises after whole bytes
        if (csRise) begin
            state_next.bitCnt   = 3'h0;
            state_next.byteCnt  = 3'h0;
            state_next.rdActive = 1'b0;
            state_next.misoOe   = 1'b0;
            if (isIdle && state_reg.bitCnt == 3'h0) begin
                case (state_reg.cmd)
                    `NVSR_CMD_LATCH_SET: if (state_reg.byteCnt == 3'h1) state_next.write_enable_latch = 1'b1;
                    `NVSR_CMD_LATCH_CLR: if (state_reg.byteCnt == 3'h1) state_next.write_enable_latch = 1'b0;
                    `NVSR_CMD_CLEAR_STATUS: begin
                        state_next.progErr  = 1'b0;
                        state_next.eraseErr = 1'b0;
                    end
                    `NVSR_CMD_SOFT_RESET: begin
                        // seed volatile flags from their defaults
                        state_next.progErr  = state_reg.status_one_nonvolatile[`NVSR_BIT_PERR];
                        state_next.eraseErr = state_reg.status_one_nonvolatile[`NVSR_BIT_EERR];
                        state_next.write_enable_latch      = state_reg.status_one_nonvolatile[`NVSR_BIT_WEL];
                        state_next.busySeed = state_reg.status_one_nonvolatile[`NVSR_BIT_BUSY];
                        state_next.bpVol    = state_reg.status_one_nonvolatile[`NVSR_BP_HI:`NVSR_BP_LO];
                        state_next.config_one_volatile     = state_reg.config_one_nonvolatile;
                    end
                    `NVSR_CMD_WRITE_REGS: begin
                        if (state_reg.write_enable_latch && !wpLock &&
                            (state_reg.byteCnt == 3'h2 || state_reg.byteCnt == 3'h3)) begin
                            newSr = (state_reg.byteCnt == 3'h2) ? state_reg.hist[7:0] : state_reg.hist[15:8];
                            if (state_reg.byteCnt == 3'h3) newCr = state_reg.hist[7:0];
                            targetsOne = 1'b1;
                        end
                    end
                    `NVSR_CMD_WRITE_ANY: begin
                        // lock pin only guards the four status/config one addresses
                        if (state_reg.write_enable_latch && state_reg.byteCnt == 3'h5) begin
                            case (state_reg.addr)
                                `NVSR_ADDR_STATUS_ONE_NONVOLATILE: begin
                                    newSr = state_reg.hist[7:0];
                                    targetsOne = !wpLock;
                                end
                                `NVSR_ADDR_CONFIG_ONE_NONVOLATILE: begin
                                    newCr = state_reg.hist[7:0];
                                    targetsOne = !wpLock;
                                end
                                `NVSR_ADDR_STATUS_ONE_VOLATILE: begin
                                    if (!wpLock && state_reg.config_one_nonvolatile[`NVSR_BIT_BP_VOLSEL]) begin
                                        state_next.bpVol = state_reg.hist[`NVSR_BP_HI:`NVSR_BP_LO];
                                        state_next.write_enable_latch   = 1'b0;
                                    end
                                end
                                `NVSR_ADDR_CONFIG_ONE_VOLATILE: begin
                                    if (!wpLock) begin
                                        state_next.config_one_volatile = state_reg.hist[7:0];
                                        state_next.write_enable_latch  = 1'b0;
                                    end
                                end
                                default: begin
                                    // unmapped targets: nothing to store, pin not consulted
                                end
                            endcase
                        end
                    end
                    `NVSR_CMD_PROGRAM, `NVSR_CMD_SECTOR_ERASE: begin
                        if (state_reg.write_enable_latch && state_reg.byteCnt >= 3'h4) begin
                            if (inProtected(state_reg.addr, activeBp)) begin
                                if (state_reg.cmd == `NVSR_CMD_PROGRAM) state_next.progErr = 1'b1;
                                else state_next.eraseErr = 1'b1;
                            end else begin
                                state_next.progPulse  = (state_reg.cmd == `NVSR_CMD_PROGRAM);
                                state_next.erasePulse = (state_reg.cmd == `NVSR_CMD_SECTOR_ERASE);
                                state_next.arrayAddr  = state_reg.addr;
                                state_next.phase      = NVSR_ARRAY_WAIT;
                                state_next.waitCnt    = 16'(NV_CYCLES - 1);
                            end
                        end
                    end
                    `NVSR_CMD_BULK_ERASE: begin
                        // refused silently; no erase error for bulk erase
                        if (state_reg.write_enable_latch && state_reg.byteCnt == 3'h1 && activeBp == 3'h0) begin
                            state_next.bulkPulse = 1'b1;
                            state_next.phase     = NVSR_ARRAY_WAIT;
                            state_next.waitCnt   = 16'(NV_CYCLES - 1);
                        end
                    end
                    default: ;
                endcase
            end
        end
        // form the new non-volatile image and launch the update
        if (targetsOne) begin
            newSr[`NVSR_BIT_PERR] = state_reg.status_one_nonvolatile[`NVSR_BIT_PERR];
            newSr[`NVSR_BIT_EERR] = state_reg.status_one_nonvolatile[`NVSR_BIT_EERR];
            newSr[`NVSR_BIT_WEL]  = state_reg.status_one_nonvolatile[`NVSR_BIT_WEL];
            newSr[`NVSR_BIT_BUSY] = state_reg.status_one_nonvolatile[`NVSR_BIT_BUSY];
            // select bit behaves one-time: once volatile, stays volatile
            newCr[`NVSR_BIT_BP_VOLSEL] = newCr[`NVSR_BIT_BP_VOLSEL] | state_reg.config_one_nonvolatile[`NVSR_BIT_BP_VOLSEL];
            if (state_reg.config_one_nonvolatile[`NVSR_BIT_BP_VOLSEL]) begin
                // only the volatile bits change, and only through the write-registers path
                if (state_reg.cmd == `NVSR_CMD_WRITE_REGS) begin
                    state_next.bpVol = newSr[`NVSR_BP_HI:`NVSR_BP_LO];
                end
                newSr[`NVSR_BP_HI:`NVSR_BP_LO] = `NVSR_BP_ALL_ONES;
            end else if (newCr[`NVSR_BIT_BP_VOLSEL]) begin
                newSr[`NVSR_BP_HI:`NVSR_BP_LO] = `NVSR_BP_ALL_ONES;
            end
            state_next.pendSr  = newSr;
            state_next.pendCr  = newCr;
            state_next.phase   = NVSR_NV_WAIT;
            state_next.waitCnt = 16'(NV_CYCLES - 1);
        end
        // internal operation timer; latch clears on completion
        if (!isIdle) begin
            if (state_reg.waitCnt != 16'h0) begin
                state_next.waitCnt = state_reg.waitCnt - 16'h1;
            end else begin
                if (state_reg.phase == NVSR_NV_WAIT) begin
                    state_next.status_one_nonvolatile = state_reg.pendSr;
                    state_next.config_one_nonvolatile = state_reg.pendCr;
                    state_next.config_one_volatile  = state_reg.pendCr;
                    if (!state_reg.pendCr[`NVSR_BIT_BP_VOLSEL]) begin
                        state_next.bpVol = state_reg.pendSr[`NVSR_BP_HI:`NVSR_BP_LO];
                    end
                end
                state_next.write_enable_latch      = 1'b0;
                state_next.busySeed = 1'b0;
                state_next.phase    = NVSR_IDLE;
            end
        end
        // busy kept in a flop of its own so the pin needs no gate behind the register
        state_next.busySeed = state_next.busySeed | (state_next.phase != NVSR_IDLE);
    end
    // ----------------------------------------
    // state register; power-on loads shipped defaults into both copies
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg          <= '0;
            state_reg.sclkPrev <= 1'b1;
            state_reg.csPrevN  <= 1'b1;
            state_reg.status_one_nonvolatile    <= `NVSR_STATUS_ONE_NONVOLATILE_RESET;
            state_reg.config_one_nonvolatile    <= `NVSR_CONFIG_ONE_NONVOLATILE_RESET;
            state_reg.config_one_volatile     <= `NVSR_CONFIG_ONE_NONVOLATILE_RESET;
            state_reg.bpVol    <= 3'(`NVSR_STATUS_ONE_NONVOLATILE_RESET >> `NVSR_BP_LO);
            state_reg.progErr  <= 1'(`NVSR_STATUS_ONE_NONVOLATILE_RESET >> `NVSR_BIT_PERR);
            state_reg.eraseErr <= 1'(`NVSR_STATUS_ONE_NONVOLATILE_RESET >> `NVSR_BIT_EERR);
            state_reg.write_enable_latch      <= 1'(`NVSR_STATUS_ONE_NONVOLATILE_RESET >> `NVSR_BIT_WEL);
            state_reg.busySeed <= 1'(`NVSR_STATUS_ONE_NONVOLATILE_RESET >> `NVSR_BIT_BUSY);
            state_reg.phase    <= NVSR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    // ----------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------
    assign miso            = state_reg.miso;
    assign misoOe          = state_reg.misoOe;
    assign busy            = state_reg.busySeed;
    assign arrayProgPulse  = state_reg.progPulse;
    assign arrayErasePulse = state_reg.erasePulse;
    assign arrayBulkPulse  = state_reg.bulkPulse;
    assign arrayAddr       = state_reg.arrayAddr;
endmodule : nvsr_top

//--- testbench/nvsr_top_assertions.sv
`timescale 1ns/1ps
module nvsr_top_assertions #(
    parameter int NV_CYCLES = 1000
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        csN,
    input wire logic        misoOe,
    input wire logic        busy,
    input wire logic        arrayProgPulse,
    input wire logic        arrayErasePulse,
    input wire logic        arrayBulkPulse,
    input wire logic [23:0] arrayAddr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [15:0] busyRun;
    // length of the current busy stretch, so the full wait is judged, not only its start
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            busyRun <= 16'h0;
        else
            busyRun <= busy ? busyRun + 16'h1 : 16'h0;
    end
    property p_prog_one; arrayProgPulse |=> !arrayProgPulse; endproperty
    a_prog_one: assert property (p_prog_one) else $error("program pulse too long");
    property p_erase_one; arrayErasePulse |=> !arrayErasePulse; endproperty
    a_erase_one: assert property (p_erase_one) else $error("erase pulse too long");
    property p_bulk_one; arrayBulkPulse |=> !arrayBulkPulse; endproperty
    a_bulk_one: assert property (p_bulk_one) else $error("bulk pulse too long");
    property p_one_op; $onehot0({arrayProgPulse, arrayErasePulse, arrayBulkPulse}); endproperty
    a_one_op: assert property (p_one_op) else $error("two array operations at once");
    property p_addr_cause; $changed(arrayAddr) |-> (arrayProgPulse || arrayErasePulse); endproperty
    a_addr_cause: assert property (p_addr_cause) else $error("address moved without operation");
    property p_oe_release; csN [*6] |-> !misoOe; endproperty
    a_oe_release: assert property (p_oe_release) else $error("output enabled while deselected");
    property p_oe_start; $rose(misoOe) |-> !csN; endproperty
    a_oe_start: assert property (p_oe_start) else $error("output enabled outside frame");
    property p_busy_len; $fell(busy) |-> busyRun >= NV_CYCLES && busyRun <= NV_CYCLES + 2; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy stretch wrong length");
endmodule : nvsr_top_assertions
bind nvsr_top nvsr_top_assertions #(.NV_CYCLES(NV_CYCLES)) chk_u (
    .mclk(mclk), .rst(rst), .csN(csN), .misoOe(misoOe), .busy(busy),
    .arrayProgPulse(arrayProgPulse), .arrayErasePulse(arrayErasePulse),
    .arrayBulkPulse(arrayBulkPulse), .arrayAddr(arrayAddr)
);

//--- testbench/nvsr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host controller, spi mode 0, 80 ns link clock
// ----------------------------------------
module nvsr_host_model (
    input  wire logic mclk,
    input  wire logic miso,
    output logic      sclk,
    output logic      csN,
    output logic      mosi
);
    // clock stands low between frames
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end
    // whole bytes msb first; last byte seen on miso is returned
    task automatic xfer(input logic [39:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge mclk) #1 csN = 1'b0;
        for (int i = 0; i < 8 * n; i++) begin
            mosi = tx[39 - i];
            repeat (10) @(posedge mclk);
            #1 rx = {rx[6:0], miso};
            sclk = 1'b1;
            repeat (10) @(posedge mclk);
            #1 sclk = 1'b0;
        end
        repeat (10) @(posedge mclk);
        #1 csN = 1'b1;
        mosi = ~mosi; // released line must not keep its last value
        repeat (12) @(posedge mclk);
    endtask : xfer
endmodule : nvsr_host_model

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "nvsr_defs.svh"
`define TB_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import nvsr_pkg::*;
    localparam int NV = 20; // short update keeps the run brief
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wpN = 1'b0;
    logic sclk, csN, mosi, miso, misoOe, busy, progP, eraseP, bulkP;
    logic [23:0] addr;
    int fail_count = 0;
    int comparisons = 0;
    int progCnt = 0;
    int bulkCnt = 0;
    int eraseCnt = 0;
    nvsr_byte_t d;
    always #2 mclk = ~mclk;
    nvsr_host_model host_u (.mclk(mclk), .miso(miso), .sclk(sclk), .csN(csN), .mosi(mosi));
    nvsr_top #(.NV_CYCLES(NV)) dut_u (.mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi),
        .wpN(wpN), .miso(miso), .misoOe(misoOe), .busy(busy), .arrayProgPulse(progP),
        .arrayErasePulse(eraseP), .arrayBulkPulse(bulkP), .arrayAddr(addr));
    // count accepted array operations
    always @(posedge mclk) begin
        if (progP === 1'b1) progCnt++;
        if (bulkP === 1'b1) bulkCnt++;
        if (eraseP === 1'b1) eraseCnt++;
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic cmd(input logic [39:0] tx, input int n);
        nvsr_byte_t r;
        host_u.xfer(tx, n, r);
    endtask : cmd
    task automatic status(output nvsr_byte_t v);
        host_u.xfer({`NVSR_CMD_READ_STATUS, 32'h0}, 2, v);
    endtask : status
    task automatic rd(input logic [23:0] a, output nvsr_byte_t v);
        host_u.xfer({`NVSR_CMD_READ_ANY, a, 8'h00}, 5, v);
    endtask : rd
    task automatic write_enable_latch();
        cmd({`NVSR_CMD_LATCH_SET, 32'h0}, 1);
    endtask : write_enable_latch
    // poll until ready; a hang ends the run
    task automatic idle();
        nvsr_byte_t v;
        for (int i = 0; i < 40; i++) begin
            status(v);
            if (v[0] === 1'b0) return;
        end
        fail_count++;
        tally_and_finish();
    endtask : idle
    task automatic op(input logic [39:0] tx, input int n);
        write_enable_latch();
        cmd(tx, n);
        idle();
    endtask : op
    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        status(d);
        `TB_CHK(d, 8'h00)
        rd(`NVSR_ADDR_STATUS_ONE_NONVOLATILE, d);
        `TB_CHK(d, `NVSR_STATUS_ONE_NONVOLATILE_RESET)
        op({`NVSR_CMD_WRITE_REGS, 8'hff, 24'h0}, 2);
        rd(`NVSR_ADDR_STATUS_ONE_NONVOLATILE, d);
        `TB_CHK(d, 8'h9c)
        status(d);
        `TB_CHK(d, 8'h9c)
        op({`NVSR_CMD_WRITE_REGS, 8'h00, 24'h0}, 2);
        op({`NVSR_CMD_WRITE_ANY, `NVSR_ADDR_CONFIG_ONE_NONVOLATILE, 8'h08}, 5);
        rd(`NVSR_ADDR_STATUS_ONE_NONVOLATILE, d);
        `TB_CHK(d, 8'h9c)
        rd(`NVSR_ADDR_CONFIG_ONE_NONVOLATILE, d);
        `TB_CHK(d, 8'h00)
        op({`NVSR_CMD_PROGRAM, 24'h000100, 8'h00}, 4);
        op({`NVSR_CMD_SECTOR_ERASE, 24'h000100, 8'h00}, 4);
        status(d);
        `TB_CHK(d[6], 1'b1)
        `TB_CHK(d[5], 1'b1)
        op({`NVSR_CMD_BULK_ERASE, 32'h0}, 1);
        `TB_CHK(bulkCnt + progCnt + eraseCnt, 0)
        cmd({`NVSR_CMD_CLEAR_STATUS, 32'h0}, 1);
        @(posedge mclk) #1 wpN = 1'b1;
        op({`NVSR_CMD_WRITE_REGS, 8'h00, 24'h0}, 2);
        rd(`NVSR_ADDR_STATUS_ONE_NONVOLATILE, d);
        `TB_CHK(d, 8'h00)
        cmd({`NVSR_CMD_LATCH_CLR, 32'h0}, 1);
        cmd({`NVSR_CMD_PROGRAM, 24'h123456, 8'h00}, 4);
        `TB_CHK(progCnt, 0)
        write_enable_latch();
        cmd({`NVSR_CMD_PROGRAM, 24'h123456, 8'h00}, 4);
        `TB_CHK(busy, 1'b1)
        idle();
        `TB_CHK(addr, 24'h123456)
        op({`NVSR_CMD_SECTOR_ERASE, 24'h654321, 8'h00}, 4);
        `TB_CHK(addr, 24'h654321)
        `TB_CHK(eraseCnt, 1)
        op({`NVSR_CMD_BULK_ERASE, 32'h0}, 1);
        `TB_CHK(bulkCnt, 1)
        op({`NVSR_CMD_WRITE_ANY, `NVSR_ADDR_CONFIG_ONE_NONVOLATILE, 8'h08}, 5);
        rd(`NVSR_ADDR_STATUS_ONE_NONVOLATILE, d);
        `TB_CHK(d, 8'h1c)
        op({`NVSR_CMD_WRITE_REGS, 8'h04, 24'h0}, 2);
        rd(`NVSR_ADDR_STATUS_ONE_NONVOLATILE, d);
        `TB_CHK(d, 8'h1c)
        status(d);
        `TB_CHK(d[4:2], 3'h1)
        cmd({`NVSR_CMD_SOFT_RESET, 32'h0}, 1);
        status(d);
        `TB_CHK(d[4:2], `NVSR_BP_ALL_ONES)
        tally_and_finish();
    end
endmodule : tb
